//--- dv/grc_global_reset_checker.sv
// grc_global_reset_checker: port timing checks of the reset request block
`timescale 1ns/1ps
`default_nettype none
module grc_global_reset_checker #(
   parameter int SOFT_CYCLES = 8
) (
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic reset_pin_n_i,
   input wire logic power_on_reset_n_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [9:0] reg_addr_i,
   input wire logic [15:0] reg_wdata_i,
   input wire logic [15:0] reg_rdata_o,
   input wire logic soft_reset_o,
   input wire logic main_reset_o
);
   // cause reads, and cycles with every reset source inactive
   logic rd_cause;
   logic quiet;
   assign rd_cause = reg_rd_i && reg_addr_i == grc_pkg::ADDR_CAUSE;
   assign quiet = reset_pin_n_i && power_on_reset_n_i && !soft_reset_o;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);
   a_soft_len: assert property ($rose(soft_reset_o) |-> soft_reset_o [*8] ##1 !soft_reset_o)
      else $error("soft reset length wrong");
   a_soft_main: assert property (soft_reset_o |-> main_reset_o)
      else $error("main reset low during soft reset");
   a_pin_main: assert property (!(reset_pin_n_i && power_on_reset_n_i) |=> main_reset_o)
      else $error("main reset missed a source");
   a_main_free: assert property (quiet && $past(reset_pin_n_i && power_on_reset_n_i) && !$past(sys_rst_i)
      |-> !main_reset_o) else $error("main reset stuck");
   a_soft_flag: assert property (rd_cause && $past(soft_reset_o) |=> reg_rdata_o[2])
      else $error("soft flag missing");
   a_por_flag: assert property (rd_cause && $past(!power_on_reset_n_i) |=> reg_rdata_o[1])
      else $error("power-on flag missing");
   a_pin_flag: assert property (rd_cause && $past(!reset_pin_n_i) |=> reg_rdata_o[0])
      else $error("pin flag missing");
   a_read_clears: assert property (rd_cause && quiet && $past(quiet) ##2 rd_cause && quiet && $past(quiet)
      |=> reg_rdata_o == 16'h0000) else $error("flags not cleared");
   a_idle_zero: assert property (!rd_cause |=> reg_rdata_o == 16'h0000)
      else $error("read data not zero");
   a_upper_zero: assert property (rd_cause |=> reg_rdata_o[15:3] == 13'h0000)
      else $error("reserved cause bits set");
   c_soft: cover property ($rose(soft_reset_o));
   c_soft_read: cover property (rd_cause ##1 reg_rdata_o[2]);
   c_pin: cover property ($fell(reset_pin_n_i));
endmodule : grc_global_reset_checker
`default_nettype wire

//--- dv/grc_global_reset_test.sv
// grc_global_reset_test: self-checking bench of the reset request and cause logic
`timescale 1ns/1ps
`default_nettype none
module grc_global_reset_test;
   logic sys_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic reset_pin_n_i = 1'b1;
   logic power_on_reset_n_i = 1'b1;
   logic reg_wr_i, reg_rd_i, soft_reset_o, main_reset_o;
   logic [9:0] reg_addr_i;
   logic [15:0] reg_wdata_i, reg_rdata_o, q;
   int n_fail = 0;
   int n_compared = 0;
   grc_global_reset dut (.sys_clk_i, .sys_rst_i, .reset_pin_n_i, .power_on_reset_n_i, .reg_wr_i, .reg_rd_i,
      .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .soft_reset_o, .main_reset_o);
   grc_host_model host (.sys_clk_i, .reg_rdata_i(reg_rdata_o), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i),
      .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i));
   // 20 MHz system clock
   initial begin
      forever #25 sys_clk_i = ~sys_clk_i;
   end
   ////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic give_verdict();
      if (n_fail == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : give_verdict
   // counts soft reset cycles over a fixed window; no pulse gives zero
   task automatic pulse(input logic [15:0] len);
      int n;
      n = 0;
      for (int i = 0; i < 30; i++) begin
         @(negedge sys_clk_i);
         if (soft_reset_o === 1'b1) n++;
         if (soft_reset_o === 1'b1) chk(16'(main_reset_o), 16'h0001);
      end
      chk(16'(n), len);
   endtask : pulse
   ////////////////////////////////////////////////////////////////
   // power-up flags: pin bit masked off, then a second read finds all clear
   task automatic t_power_up();
      host.rd(grc_pkg::ADDR_CAUSE, q);
      chk(q & 16'hfffe, 16'h0002);
      host.rd(grc_pkg::ADDR_CAUSE, q);
      chk(q, 16'h0000);
   endtask : t_power_up
   // full code, then a lone high half must not fire again
   task automatic t_soft();
      host.wr(grc_pkg::ADDR_CODE_LOW, grc_pkg::CODE_LOW_KEY);
      host.wr(grc_pkg::ADDR_CODE_HIGH, grc_pkg::CODE_HIGH_KEY);
      pulse(16'h0008);
      host.rd(grc_pkg::ADDR_CAUSE, q);
      chk(q, 16'h0004);
      host.wr(grc_pkg::ADDR_CODE_HIGH, grc_pkg::CODE_HIGH_KEY);
      pulse(16'h0000);
      host.rd(grc_pkg::ADDR_CODE_LOW, q);
      chk(q, 16'h0000);
   endtask : t_soft
   // wrong low half is harmless; correcting it later completes the pair
   task automatic t_codes();
      host.wr(grc_pkg::ADDR_CODE_LOW, grc_pkg::CODE_LOW_KEY ^ 16'h8000);
      host.wr(grc_pkg::ADDR_CODE_HIGH, grc_pkg::CODE_HIGH_KEY);
      pulse(16'h0000);
      host.wr(grc_pkg::ADDR_CODE_LOW, grc_pkg::CODE_LOW_KEY);
      pulse(16'h0008);
      host.rd(grc_pkg::ADDR_CAUSE, q);
      chk(q, 16'h0004);
   endtask : t_codes
   // pin then power-on source: main reset follows, each sets its own flag
   task automatic t_pins();
      for (int k = 0; k < 2; k++) begin
         @(posedge sys_clk_i);
         reset_pin_n_i <= k[0];
         power_on_reset_n_i <= !k[0];
         repeat (3) @(negedge sys_clk_i);
         chk(16'(main_reset_o), 16'h0001);
         @(posedge sys_clk_i);
         reset_pin_n_i <= 1'b1;
         power_on_reset_n_i <= 1'b1;
         repeat (3) @(negedge sys_clk_i);
         chk(16'(main_reset_o), 16'h0000);
         host.rd(grc_pkg::ADDR_CAUSE, q);
         chk(q, 16'h0001 << k);
      end
   endtask : t_pins
   // reads while a source is still active keep the flag; a write of the cause word clears it
   task automatic t_live();
      for (int k = 0; k < 2; k++) begin
         @(posedge sys_clk_i);
         reset_pin_n_i <= k[0];
         power_on_reset_n_i <= !k[0];
         host.rd(grc_pkg::ADDR_CAUSE, q);
         chk(q, 16'h0001 << k);
         host.rd(grc_pkg::ADDR_CAUSE, q);
         chk(q, 16'h0001 << k);
         @(posedge sys_clk_i);
         reset_pin_n_i <= 1'b1;
         power_on_reset_n_i <= 1'b1;
         host.wr(grc_pkg::ADDR_CAUSE, 16'hffff);
         host.rd(grc_pkg::ADDR_CAUSE, q);
         chk(q, 16'h0000);
      end
      host.wr(grc_pkg::ADDR_CODE_LOW, grc_pkg::CODE_LOW_KEY);
      host.wr(grc_pkg::ADDR_CODE_HIGH, grc_pkg::CODE_HIGH_KEY);
      host.rd(grc_pkg::ADDR_CAUSE, q);
      chk(q, 16'h0000);
      host.rd(grc_pkg::ADDR_CAUSE, q);
      chk(q, 16'h0004);
      repeat (12) @(negedge sys_clk_i);
      host.rd(grc_pkg::ADDR_CAUSE, q);
      chk(q, 16'h0004);
   endtask : t_live
   initial begin
      repeat (8) @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
      t_power_up();
      t_soft();
      t_codes();
      t_pins();
      t_live();
      give_verdict();
   end
endmodule : grc_global_reset_test
bind grc_global_reset grc_global_reset_checker #(.SOFT_CYCLES(SOFT_CYCLES)) chk_i (.sys_clk_i, .sys_rst_i,
   .reset_pin_n_i, .power_on_reset_n_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o,
   .soft_reset_o, .main_reset_o);
`default_nettype wire

//--- dv/grc_host_model.sv
// grc_host_model: register-port master standing in for the serial host
`timescale 1ns/1ps
`default_nettype none
module grc_host_model (
   input wire logic sys_clk_i,
   input wire logic [15:0] reg_rdata_i,
   output logic reg_wr_o = 1'b0,
   output logic reg_rd_o = 1'b0,
   output logic [9:0] reg_addr_o = 10'h000,
   output logic [15:0] reg_wdata_o = 16'h0000
);
   // one word per strobe; data lines are scrambled after use, since a real host leaves no stale value
   task automatic wr(input logic [9:0] a, input logic [15:0] d);
      @(posedge sys_clk_i);
      reg_wr_o <= 1'b1;
      reg_addr_o <= a;
      reg_wdata_o <= d;
      @(posedge sys_clk_i);
      reg_wr_o <= 1'b0;
      reg_wdata_o <= ~d;
   endtask : wr
   // read data is taken one cycle after the strobe edge, mid-cycle
   task automatic rd(input logic [9:0] a, output logic [15:0] q);
      @(posedge sys_clk_i);
      reg_rd_o <= 1'b1;
      reg_addr_o <= a;
      @(posedge sys_clk_i);
      reg_rd_o <= 1'b0;
      @(negedge sys_clk_i);
      q = reg_rdata_i;
   endtask : rd
endmodule : grc_host_model
`default_nettype wire

//--- hw/grc_global_reset.sv
// grc_global_reset: software reset request, main reset generation and sticky reset cause register
// Behaviour worth knowing
// - only sys_rst_i clears this block; main_reset_o never feeds back into it
// - a wrong half stays stored and harmless until it is overwritten
// - code writes are dropped while the pulse runs, so it cannot re-arm early
// - read data is registered and stands for one cycle after the read strobe
// - the code halves are write-only and read back as zero
// - main_reset_o is registered, so it follows the pin and power-on sources one cycle late and rises with soft_reset_o
// - a flag set by a source in the cycle of an access survives the clear
// - the pulse length is the SOFT_CYCLES parameter, eight by default
`timescale 1ns/1ps
`default_nettype none
module grc_global_reset #(
   parameter int SOFT_CYCLES = grc_pkg::SOFT_RST_CYCLES
) (
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic reset_pin_n_i,
   input wire logic power_on_reset_n_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [grc_pkg::ADDR_W-1:0] reg_addr_i,
   input wire logic [grc_pkg::DATA_W-1:0] reg_wdata_i,
   output logic [grc_pkg::DATA_W-1:0] reg_rdata_o,
   output logic soft_reset_o,
   output logic main_reset_o
);

   ////////////////////////////////////////////////////////////////////////////
   // state

   // this block runs on sys_rst_i only; it is never hit by the reset it makes
   logic [grc_pkg::DATA_W-1:0] code_low_reg;
   logic [grc_pkg::DATA_W-1:0] code_low_next;
   logic [grc_pkg::DATA_W-1:0] code_high_reg;
   logic [grc_pkg::DATA_W-1:0] code_high_next;
   // sticky flags, one per reset source
   logic [grc_pkg::CAUSE_W-1:0] cause_reg;
   logic [grc_pkg::CAUSE_W-1:0] cause_next;
   // pulse length counter and sequencer state
   logic [grc_pkg::SOFT_CNT_W-1:0] cnt_reg;
   logic [grc_pkg::SOFT_CNT_W-1:0] cnt_next;
   grc_pkg::grc_state_t state_reg;
   grc_pkg::grc_state_t state_next;
   // registered outputs and read data
   logic soft_reg;
   logic soft_next;
   logic main_reg;
   logic main_next;
   logic [grc_pkg::DATA_W-1:0] rdata_reg;
   logic [grc_pkg::DATA_W-1:0] rdata_next;

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   // address compare used by every register decode
   // kept as a function so every decode compares the full word address
   function automatic logic hit(input logic [grc_pkg::ADDR_W-1:0] addr,
                                input logic [grc_pkg::ADDR_W-1:0] target);
      hit = (addr == target);
   endfunction : hit

   // pulse length as a counter value, cut to the counter width on purpose
   // limitation: the counter holds 16 counts, so SOFT_CYCLES must stay at 16 or below
   localparam logic [grc_pkg::SOFT_CNT_W-1:0] LAST_CNT = grc_pkg::SOFT_CNT_W'(SOFT_CYCLES - 1);

   ////////////////////////////////////////////////////////////////////////////
   // register port decode

   // each code half has its own word address
   wire wr_low = reg_wr_i && hit(reg_addr_i, grc_pkg::ADDR_CODE_LOW);
   wire wr_high = reg_wr_i && hit(reg_addr_i, grc_pkg::ADDR_CODE_HIGH);
   // a read or a write of the cause word counts as an access
   wire cause_access = (reg_wr_i || reg_rd_i) && hit(reg_addr_i, grc_pkg::ADDR_CAUSE);
   // only a read of the cause word puts data on the read port
   wire cause_read = reg_rd_i && hit(reg_addr_i, grc_pkg::ADDR_CAUSE);

   // both halves must hold their key together; a lone half does nothing
   wire code_match = (code_low_reg == grc_pkg::CODE_LOW_KEY) &&
                     (code_high_reg == grc_pkg::CODE_HIGH_KEY);

   // source levels, active high
   wire pin_active = !reset_pin_n_i;
   wire por_active = !power_on_reset_n_i;

   ////////////////////////////////////////////////////////////////////////////
   // software reset sequencer

   // idle waits for a full match, pulse holds the request for a fixed count
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      soft_next = soft_reg;
      code_low_next = code_low_reg;
      code_high_next = code_high_reg;
      case (state_reg)
         grc_pkg::GRC_IDLE: begin
            // each half is written on its own address
            if (wr_low) begin
               code_low_next = reg_wdata_i;
            end
            if (wr_high) begin
               code_high_next = reg_wdata_i;
            end
            // the match is taken from the stored halves, one cycle after the last write
            if (code_match) begin
               state_next = grc_pkg::GRC_PULSE;
               cnt_next = '0;
               soft_next = 1'b1;
            end
         end
         grc_pkg::GRC_PULSE: begin
            // writes during the pulse are dropped so the code cannot re-arm early
            // count the cycles of the pulse; the last one closes it
            if (cnt_reg == LAST_CNT) begin
               state_next = grc_pkg::GRC_IDLE;
               soft_next = 1'b0;
               code_low_next = grc_pkg::CODE_RESET;
               code_high_next = grc_pkg::CODE_RESET;
            end else begin
               cnt_next = cnt_reg + 1'b1;
            end
         end
         default: begin
            // an illegal state falls back to idle with the request low
            state_next = grc_pkg::GRC_IDLE;
            soft_next = 1'b0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // sticky reset cause

   // a source active in the access cycle sets its flag again: set beats clear
   always_comb begin
      cause_next = cause_access ? '0 : cause_reg;
      if (pin_active) begin
         cause_next[grc_pkg::CAUSE_PIN_BIT] = 1'b1;
      end
      if (por_active) begin
         cause_next[grc_pkg::CAUSE_POR_BIT] = 1'b1;
      end
      // the soft flag follows the registered request, so it sets while the pulse runs
      if (soft_reg) begin
         cause_next[grc_pkg::CAUSE_SOFT_BIT] = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // main reset and read data

   // any source holds the device in reset; release waits for a clock edge
   // trade-off: registering costs one cycle of latency but keeps the output glitch free
   assign main_next = soft_next || pin_active || por_active;

   // read data shows the flags as they stood before the access clears them
   // unmapped and write-only words read back as zero
   assign rdata_next = cause_read ? {{(grc_pkg::DATA_W - grc_pkg::CAUSE_W){1'b0}}, cause_reg} : '0;

   ////////////////////////////////////////////////////////////////////////////
   // flip-flops

   // sequencer and code halves
   // sys_rst_i is the only reset seen here, so the block survives its own pulse
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         state_reg <= grc_pkg::GRC_IDLE;
         cnt_reg <= '0;
         soft_reg <= 1'b0;
         code_low_reg <= grc_pkg::CODE_RESET;
         code_high_reg <= grc_pkg::CODE_RESET;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         soft_reg <= soft_next;
         code_low_reg <= code_low_next;
         code_high_reg <= code_high_next;
      end
   end

   // cause flags; after a power-up only the power-on flag is meaningful
   // the pin flag starts cleared but holds no meaning until the first read
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         cause_reg <= grc_pkg::CAUSE_RESET;
      end else begin
         cause_reg <= cause_next;
      end
   end

   // outputs, all registered
   // main reset is held during sys_rst_i so the device starts in reset
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         main_reg <= 1'b1;
         rdata_reg <= '0;
      end else begin
         main_reg <= main_next;
         rdata_reg <= rdata_next;
      end
   end

   // ports come straight from the flip-flops above
   assign reg_rdata_o = rdata_reg;
   assign soft_reset_o = soft_reg;
   assign main_reset_o = main_reg;

endmodule : grc_global_reset
`default_nettype wire

//--- shared/grc_pkg.sv
// grc_pkg: constants of the global reset request and reset cause logic
`default_nettype none
package grc_pkg;
   // register word addresses on the internal register port
   localparam logic [9:0] ADDR_CODE_LOW = 10'h1d0;
   localparam logic [9:0] ADDR_CODE_HIGH = 10'h1d1;
   localparam logic [9:0] ADDR_CAUSE = 10'h1d6;
   // widths
   localparam int ADDR_W = 10;
   localparam int DATA_W = 16;
   localparam int CAUSE_W = 3;
   // reset code pair
   localparam logic [15:0] CODE_LOW_KEY = 16'hf473;
   localparam logic [15:0] CODE_HIGH_KEY = 16'h57a1;
   // reset values
   localparam logic [15:0] CODE_RESET = 16'h0000;
   localparam logic [2:0] CAUSE_RESET = 3'h2;
   // reset cause field positions
   localparam int CAUSE_PIN_BIT = 0;
   localparam int CAUSE_POR_BIT = 1;
   localparam int CAUSE_SOFT_BIT = 2;
   // software reset length in system clock cycles
   localparam int SOFT_RST_CYCLES = 8;
   localparam int SOFT_CNT_W = 4;
   // sequencer states
   typedef enum logic [0:0] {GRC_IDLE, GRC_PULSE} grc_state_t;
endpackage : grc_pkg
`default_nettype wire
